// ---- hw/evb_source.sv ----
// evb source board end: staging fifo, event queue, framer, burst target
`timescale 1ns/1ns
`default_nettype none
`include "evb_map.svh"

module evb_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
  } evb_fifo_st_t;
  evb_fifo_st_t st;
  evb_fifo_st_t next_st;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = (st.count != CW'(DEPTH));
  assign out_valid_o = (st.count != '0);
  assign out_data_o = mem[st.rptr];
  assign push = in_valid_i && in_ready_o && ce_i;
  assign pop = out_valid_o && out_ready_i && ce_i;

  always_comb
  begin
    next_st = st;
    // depth need not be a power of two, so pointers wrap explicitly
    if (push)
    begin
      next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
    end
    if (pop)
    begin
      next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
    end
    case ({push, pop})
      2'b10: next_st.count = st.count + 1'b1;
      2'b01: next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      st <= '0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  // storage has no reset; only the pointers matter
  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem[st.wptr] <= in_data_i;
    end
  end
endmodule : evb_fifo

// Functional notes
// - event buffer is a fifo, one read address
// - queue depth at least variant minimum
// - first word low byte carries crossing number
// - next-to-last word holds total word count
// - last word is 32-bit parity checksum
// - collector checks crossing, count, checksum, flags errors
// - burst transfer: collector master, board target
// - raise data-ready while queue holds data
// - collector requests burst, raises busy with request
// - target ready only with whole block stored
// - target ready follows final word's write
// - collector reads block once target ready
// - disconnect without data after final word
// - drop data-ready together with the disconnect
module evb_source (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  evb_if.dev link,
  input wire logic evt_valid_i,
  output logic evt_ready_o,
  input wire logic [31:0] evt_data_i,
  input wire logic evt_last_i,
  input wire logic [7:0] crossing_number_i,
  output logic [7:0] blocks_stored_o
);
  import evb_pkg::*;
  localparam int SW = `EVB_WORD_W + `EVB_BX_W + 1;
  localparam int QW = `EVB_WORD_W + 1;

  evb_src_st_t st;
  evb_src_st_t next_st;
  logic s_valid;
  logic s_ready;
  logic [SW-1:0] s_data;
  logic s_last;
  logic [`EVB_BX_W-1:0] s_bx;
  evb_word_t s_word;
  logic q_in_valid;
  logic q_in_ready;
  evb_word_t q_in_word;
  logic q_in_last;
  logic q_out_valid;
  logic [QW-1:0] q_out_data;
  logic q_out_last;
  logic xfer;
  logic blk_in;
  logic blk_out;

  // staging absorbs user words while the framer inserts head and trailer
  evb_fifo #(
    .W(SW),
    .DEPTH(`EVB_STAGE_DEPTH)
  ) u_stage (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_valid_i(evt_valid_i),
    .in_ready_o(evt_ready_o),
    .in_data_i({evt_last_i, crossing_number_i, evt_data_i}),
    .out_valid_o(s_valid),
    .out_ready_i(s_ready),
    .out_data_o(s_data)
  );

  // one fifo queue, read at a fixed port
  evb_fifo #(
    .W(QW),
    .DEPTH(`EVB_QUEUE_DEPTH)
  ) u_queue (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_valid_i(q_in_valid),
    .in_ready_o(q_in_ready),
    .in_data_i({q_in_last, q_in_word}),
    .out_valid_o(q_out_valid),
    .out_ready_i(xfer),
    .out_data_o(q_out_data)
  );

  assign s_last = s_data[SW-1];
  assign s_bx = s_data[SW-2:`EVB_WORD_W];
  assign s_word = s_data[`EVB_WORD_W-1:0];
  assign q_out_last = q_out_data[QW-1];
  assign blocks_stored_o = st.blocks;

  // board only answers the collector's burst
  assign xfer = link.burst_req && !link.target_ready_n;
  assign link.rd_data = q_out_data[`EVB_WORD_W-1:0];
  // ready once a whole block sits in the queue
  assign link.target_ready_n = !((st.dstate == D_XFER) && link.burst_req
                                 && (st.blocks != '0) && q_out_valid);
  // stop with ready high: disconnect without data
  assign link.target_stop = (st.dstate == D_STOP);
  // raised on first word, dropped during the stop
  assign link.event_data_ready = q_out_valid && (st.dstate != D_STOP);

  assign blk_in = (st.fstate == F_SUM) && q_in_ready && ce_i;
  assign blk_out = xfer && q_out_last && ce_i;

  always_comb
  begin
    next_st = st;
    s_ready = 1'b0;
    q_in_valid = 1'b0;
    q_in_word = '0;
    q_in_last = 1'b0;
    case (st.fstate)
      F_HEAD:
      begin
        q_in_valid = s_valid;
        // crossing number as received, zeros above
        q_in_word = {`EVB_HDR_PAD, s_bx};
        if (s_valid && q_in_ready)
        begin
          // parity starts from the head word
          next_st.parity = q_in_word;
          next_st.count = `EVB_HEAD_WORDS;
          next_st.fstate = F_BODY;
        end
      end
      F_BODY:
      begin
        q_in_valid = s_valid;
        q_in_word = s_word;
        s_ready = q_in_ready;
        if (s_valid && q_in_ready)
        begin
          next_st.parity = st.parity ^ s_word;
          next_st.count = st.count + 1'b1;
          if (s_last)
          begin
            next_st.fstate = F_COUNT;
          end
        end
      end
      F_COUNT:
      begin
        q_in_valid = 1'b1;
        // total includes count word and checksum
        q_in_word = {`EVB_CNT_PAD, st.count + `EVB_TRAILER_WORDS};
        if (q_in_ready)
        begin
          next_st.parity = st.parity ^ q_in_word;
          next_st.fstate = F_SUM;
        end
      end
      F_SUM:
      begin
        q_in_valid = 1'b1;
        q_in_word = st.parity;
        q_in_last = 1'b1;
        next_st.fstate = q_in_ready ? F_HEAD : F_SUM;
      end
      default: next_st.fstate = F_HEAD;
    endcase

    case ({blk_in, blk_out})
      2'b10: next_st.blocks = st.blocks + 1'b1;
      2'b01: next_st.blocks = st.blocks - 1'b1;
      default: next_st.blocks = st.blocks;
    endcase

    case (st.dstate)
      D_IDLE: next_st.dstate = link.burst_req ? D_XFER : D_IDLE;
      // the final word ends the burst
      D_XFER: next_st.dstate = (xfer && q_out_last) ? D_STOP : D_XFER;
      // stop held until the master lets go, so no word slips after it
      D_STOP: next_st.dstate = link.burst_req ? D_STOP : D_IDLE;
      default: next_st.dstate = D_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      st <= '{fstate: F_HEAD, dstate: D_IDLE, count: '0, parity: '0, blocks: '0};
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end
endmodule : evb_source
`default_nettype wire

// ---- hw/evb_map.svh ----
// evb constants: widths, depths and word layout
`ifndef EVB_MAP_SVH
`define EVB_MAP_SVH
`define EVB_WORD_W 32
`define EVB_BX_W 8
`define EVB_BX_LSB 0
`define EVB_HDR_PAD_W 24
`define EVB_HDR_PAD 24'h000000
`define EVB_CNT_W 16
`define EVB_CNT_PAD 16'h0000
`define EVB_TRAILER_WORDS 16'h0002
`define EVB_HEAD_WORDS 16'h0001
`define EVB_QUEUE_DEPTH 154
`define EVB_QUEUE_DEPTH_ALT_A 9216
`define EVB_QUEUE_DEPTH_ALT_B 6267
`define EVB_STAGE_DEPTH 8
`define EVB_BLK_W 8
`define EVB_MIN_BLOCK_WORDS 16'h0003
`endif

// ---- hw/evb_pkg.sv ----
// evb package: state types shared by both ends
`default_nettype none
`include "evb_map.svh"
package evb_pkg;
  typedef logic [`EVB_WORD_W-1:0] evb_word_t;
  typedef enum logic [3:0] {
    F_HEAD = 4'b0001,
    F_BODY = 4'b0010,
    F_COUNT = 4'b0100,
    F_SUM = 4'b1000
  } evb_fill_t;
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_XFER = 3'b010,
    D_STOP = 3'b100
  } evb_xfer_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_READ = 3'b010,
    M_DONE = 3'b100
  } evb_mst_t;
  typedef struct packed {
    evb_fill_t fstate;
    evb_xfer_t dstate;
    logic [`EVB_CNT_W-1:0] count;
    evb_word_t parity;
    logic [`EVB_BLK_W-1:0] blocks;
  } evb_src_st_t;
  typedef struct packed {
    evb_mst_t mstate;
    logic [`EVB_CNT_W-1:0] nwords;
    evb_word_t prev;
    evb_word_t prev2;
    evb_word_t par;
    logic bx_bad;
    evb_word_t word;
    logic word_valid;
    logic done;
    logic err_crossing;
    logic err_count;
    logic err_sum;
  } evb_col_st_t;
endpackage : evb_pkg
`default_nettype wire

// ---- hw/evb_if.sv ----
// evb link between source board and buffer collector
`timescale 1ns/1ns
`default_nettype none
interface evb_if;
  import evb_pkg::*;
  logic event_data_ready;
  logic collector_busy;
  logic burst_req;
  logic target_ready_n;
  logic target_stop;
  evb_word_t rd_data;
  modport dev (
    output event_data_ready,
    output target_ready_n,
    output target_stop,
    output rd_data,
    input collector_busy,
    input burst_req
  );
  modport mst (
    input event_data_ready,
    input target_ready_n,
    input target_stop,
    input rd_data,
    output collector_busy,
    output burst_req
  );
endinterface : evb_if
`default_nettype wire

// ---- hw/evb_collector.sv ----
// evb buffer collector end: burst master and block checker
`timescale 1ns/1ns
`default_nettype none
`include "evb_map.svh"
module evb_collector (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  evb_if.mst link,
  input wire logic [7:0] expected_crossing_i,
  output logic [31:0] word_o,
  output logic word_valid_o,
  output logic block_done_o,
  output logic err_crossing_o,
  output logic err_count_o,
  output logic err_sum_o
);
  import evb_pkg::*;
  evb_col_st_t st;
  evb_col_st_t next_st;
  logic beat;

  // request and busy rise together, master side only
  assign link.burst_req = (st.mstate == M_READ);
  // busy falls once the disconnect has been seen
  assign link.collector_busy = (st.mstate == M_READ);
  assign beat = link.burst_req && !link.target_ready_n;

  assign word_o = st.word;
  assign word_valid_o = st.word_valid;
  assign block_done_o = st.done;
  assign err_crossing_o = st.err_crossing;
  assign err_count_o = st.err_count;
  assign err_sum_o = st.err_sum;

  always_comb
  begin
    next_st = st;
    next_st.word_valid = 1'b0;
    next_st.done = 1'b0;
    next_st.err_crossing = 1'b0;
    next_st.err_count = 1'b0;
    next_st.err_sum = 1'b0;
    case (st.mstate)
      M_IDLE:
      begin
        if (link.event_data_ready)
        begin
          next_st.mstate = M_READ;
          next_st.nwords = '0;
          next_st.par = '0;
          next_st.bx_bad = 1'b0;
        end
      end
      M_READ:
      begin
        // words move only while the target is ready
        if (beat)
        begin
          next_st.nwords = st.nwords + 1'b1;
          // xor of every word, checksum included, must be zero
          next_st.par = st.par ^ link.rd_data;
          next_st.prev2 = st.prev;
          next_st.prev = link.rd_data;
          next_st.word = link.rd_data;
          next_st.word_valid = 1'b1;
          if (st.nwords == '0)
          begin
            next_st.bx_bad = (link.rd_data[`EVB_BX_W-1:`EVB_BX_LSB] != expected_crossing_i);
          end
        end
        else if (link.target_stop)
        begin
          // all three checks reported with the done pulse
          next_st.mstate = M_DONE;
          next_st.done = 1'b1;
          next_st.err_crossing = st.bx_bad;
          next_st.err_count = (st.nwords < `EVB_MIN_BLOCK_WORDS)
                              || (st.prev2 != {`EVB_CNT_PAD, st.nwords});
          next_st.err_sum = (st.par != '0);
        end
      end
      M_DONE:
      begin
        next_st.mstate = M_IDLE;
      end
      default:
      begin
        next_st.mstate = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      st <= '{mstate: M_IDLE, default: '0};
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end
endmodule : evb_collector
`default_nettype wire

// ---- tb/evb_chk.sv ----
// evb link checker: handshake and framing assertions
`timescale 1ns/1ns
`default_nettype none
module evb_chk (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic event_data_ready_i,
  input wire logic collector_busy_i,
  input wire logic burst_req_i,
  input wire logic target_ready_n_i,
  input wire logic target_stop_i,
  input wire evb_pkg::evb_word_t rd_data_i
);
  import evb_pkg::*;
  evb_word_t acc;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || !burst_req_i)
      acc <= '0;
    else if (!target_ready_n_i)
      acc <= acc ^ rd_data_i;
  end
  AST_READY_IN_BURST: assert property (!target_ready_n_i |-> burst_req_i)
    else $error("target ready outside a burst");
  AST_BUSY_WITH_REQ: assert property (burst_req_i == collector_busy_i)
    else $error("busy and request differ");
  AST_REQ_AFTER_DATA: assert property (
    $rose(burst_req_i) |-> $past(event_data_ready_i))
    else $error("request without data ready");
  AST_REQ_FOLLOWS: assert property (
    $rose(event_data_ready_i) && !burst_req_i |-> ##[1:4] burst_req_i)
    else $error("no request after data ready");
  AST_STOP_NO_DATA: assert property (target_stop_i |-> target_ready_n_i)
    else $error("data moved during disconnect");
  AST_STOP_DROPS_DATA: assert property (
    $rose(target_stop_i) |-> !event_data_ready_i)
    else $error("data ready kept at disconnect");
  AST_STOP_ENDS_REQ: assert property ($rose(target_stop_i) |=> !burst_req_i)
    else $error("request kept after disconnect");
  AST_STOP_RELEASE: assert property (
    $fell(burst_req_i) |-> target_stop_i ##1 !target_stop_i)
    else $error("disconnect not held to request end");
  AST_HEAD_PAD: assert property (
    $fell(target_ready_n_i) |-> rd_data_i[31:8] == 24'h000000)
    else $error("head word upper bits not zero");
  AST_SUM_ZERO: assert property ($rose(target_stop_i) |-> acc == 32'h00000000)
    else $error("block parity not zero");
endmodule : evb_chk
`default_nettype wire

// ---- tb/tb_event_block_buffer_readout.sv ----
// evb bench: both ends joined, framing and handshake scenarios
`timescale 1ns/1ns
`default_nettype none
module tb_event_block_buffer_readout;
  import evb_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce = 1'b1;
  logic evt_valid = 1'b0;
  logic evt_last = 1'b0;
  logic [31:0] evt_data = 32'h00000000;
  logic [7:0] bx = 8'h00;
  logic [7:0] exp_bx = 8'h00;
  logic evt_ready, word_valid, done, e_bx, e_cnt, e_sum, rq_q;
  logic [7:0] blocks;
  logic [31:0] word;
  logic [2:0] errs;
  int mismatches = 0;
  int checked = 0;
  int dn = 0;
  int nb = 0;
  logic [31:0] got[$];
  logic [31:0] exp_q[$];
  evb_if u_evb_if ();
  evb_source u_evb_source (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce),
    .link(u_evb_if.dev), .evt_valid_i(evt_valid), .evt_ready_o(evt_ready),
    .evt_data_i(evt_data), .evt_last_i(evt_last), .crossing_number_i(bx),
    .blocks_stored_o(blocks));
  evb_collector u_evb_collector (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce),
    .link(u_evb_if.mst), .expected_crossing_i(exp_bx), .word_o(word),
    .word_valid_o(word_valid), .block_done_o(done), .err_crossing_o(e_bx),
    .err_count_o(e_cnt), .err_sum_o(e_sum));
  evb_chk u_evb_chk (.clock_i(clock_i), .rstn_i(rstn_i),
    .event_data_ready_i(u_evb_if.event_data_ready),
    .collector_busy_i(u_evb_if.collector_busy),
    .burst_req_i(u_evb_if.burst_req),
    .target_ready_n_i(u_evb_if.target_ready_n),
    .target_stop_i(u_evb_if.target_stop),
    .rd_data_i(u_evb_if.rd_data));
  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    if (word_valid)
      got.push_back(word);
    if (done)
    begin
      dn <= dn + 1;
      errs <= {e_bx, e_cnt, e_sum};
    end
    if (u_evb_if.burst_req && !rq_q)
      nb <= nb + 1;
    rq_q <= u_evb_if.burst_req;
  end
  task chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // one event in; builds the expected block alongside
  task push_evt(input logic [7:0] x, input int n, input bit rdy_chk);
    logic [31:0] par, w;
    int k;
    par = {24'h000000, x};
    exp_q.push_back(par);
    for (int i = 0; i < n; i++)
    begin
      w = {16'hc0de, x, 8'(i)};
      evt_valid = 1'b1;
      evt_data = w;
      evt_last = (i == n - 1);
      bx = x;
      if (rdy_chk)
        chk(32'(u_evb_if.target_ready_n), 32'h1); // still waiting
      k = 0;
      while (!evt_ready && k < 50)
      begin
        @(negedge clock_i);
        k++;
      end
      if (k == 50)
      begin
        mismatches++;
        wrap_up();
      end
      @(negedge clock_i);
      par = par ^ w;
      exp_q.push_back(w);
    end
    evt_valid = 1'b0;
    evt_last = 1'b0;
    // an idle edge, so the next event never retoggles valid in one step
    @(negedge clock_i);
    w = {16'h0000, 16'(n + 3)};
    exp_q.push_back(w);
    exp_q.push_back(par ^ w);
  endtask : push_evt
  // bounded wait, then compare every collected word
  task wait_blk(input int want, input logic [2:0] werr);
    int k;
    k = 0;
    while (dn < want && k < 400)
    begin
      @(negedge clock_i);
      k++;
    end
    if (k == 400)
    begin
      mismatches++;
      wrap_up();
    end
    chk(32'(errs), 32'(werr)); // error flags
    chk(32'(got.size()), 32'(exp_q.size())); // block length
    foreach (exp_q[i])
      chk(got[i], exp_q[i]); // words in order
    got.delete();
    exp_q.delete();
  endtask : wait_blk
  task sc_reset;
    chk(32'(u_evb_if.event_data_ready), 32'h0); // idle
    chk(32'(u_evb_if.target_ready_n), 32'h1); // idle
    chk(32'(blocks), 32'h0); // empty queue
  endtask : sc_reset
  task sc_single;
    int d0;
    d0 = dn;
    exp_bx = 8'h3c;
    push_evt(8'h3c, 1, 1'b1);
    chk(32'(u_evb_if.event_data_ready), 32'h1); // raised early
    repeat (2) @(negedge clock_i);
    chk(32'(u_evb_if.target_ready_n), 32'h1); // checksum not stored yet
    @(negedge clock_i);
    chk(32'(u_evb_if.target_ready_n), 32'h0); // ready after final write
    chk(u_evb_if.rd_data, 32'h0000003c); // head word leads
    wait_blk(d0 + 1, 3'b000);
    chk(32'(blocks), 32'h0); // drained
  endtask : sc_single
  task sc_b2b;
    int d0, n0;
    d0 = dn;
    n0 = nb;
    exp_bx = 8'hff;
    push_evt(8'hff, 12, 1'b1);
    push_evt(8'hff, 2, 1'b0);
    wait_blk(d0 + 2, 3'b000);
    chk(32'(nb - n0), 32'h2); // one block per burst
  endtask : sc_b2b
  task sc_bad_bx;
    int d0;
    d0 = dn;
    exp_bx = 8'h11;
    push_evt(8'h12, 3, 1'b1);
    wait_blk(d0 + 1, 3'b100);
  endtask : sc_bad_bx
  // clock enable low freezes both ends mid-fill
  task sc_freeze;
    int d0, n0;
    d0 = dn;
    n0 = nb;
    exp_bx = 8'h5a;
    push_evt(8'h5a, 2, 1'b1);
    ce = 1'b0;
    repeat (8) @(negedge clock_i);
    chk(32'(blocks), 32'h0); // fill frozen
    chk(32'(u_evb_if.target_ready_n), 32'h1); // no ready while frozen
    chk(32'(nb - n0), 32'h1); // one request only
    ce = 1'b1;
    wait_blk(d0 + 1, 3'b000);
  endtask : sc_freeze
  initial
  begin
    repeat (16) @(negedge clock_i);
    sc_reset();
    rstn_i = 1'b1;
    @(negedge clock_i);
    sc_single();
    sc_b2b();
    sc_bad_bx();
    sc_freeze();
    wrap_up();
  end
endmodule : tb_event_block_buffer_readout
`default_nettype wire
